/* File: rtl/cssc_params.svh */
// Constants for the capacitive sense scan controller: register addresses, fields, resets.
// Assumes inclusion by bare name from the package and the controller module.
`ifndef CSSC_PARAMS_SVH
`define CSSC_PARAMS_SVH

`define CSSC_ADDR_CONFIG 8'hb0
`define CSSC_ADDR_CONTROL 8'hb1
`define CSSC_ADDR_SCAN_START 8'hb9
`define CSSC_ADDR_SCAN_END 8'hba
`define CSSC_ADDR_MUX_SELECT 8'hbb
`define CSSC_CFG_SRC_HI 6
`define CSSC_CFG_SRC_LO 4
`define CSSC_CFG_ACC_HI 1
`define CSSC_CFG_ACC_LO 0
`define CSSC_CTL_BUSY 1
`define CSSC_CTL_IRQ_FLAG 0
`define CSSC_RESET_BYTE 8'h00
`define CSSC_CONV_TIME_NS 38000
`define CSSC_CLK_PERIOD_NS 10
`define CSSC_CONV_CYCLES (`CSSC_CONV_TIME_NS / `CSSC_CLK_PERIOD_NS)

`endif

/* File: rtl/cssc_pkg.sv */
// Types shared by the capacitive sense scan controller.
// Assumes the parameter header sits beside it in rtl/.
`include "cssc_params.svh"

package cssc_pkg;

    // Start-source codes of the three-bit trigger field.
    typedef enum logic [2:0] {
        cssc_src_software = 3'h0,
        cssc_src_timer0 = 3'h1,
        cssc_src_timer2 = 3'h2,
        cssc_src_timer1 = 3'h3,
        cssc_src_continuous = 3'h4,
        cssc_src_rsvd5 = 3'h5,
        cssc_src_rsvd6 = 3'h6,
        cssc_src_autoscan = 3'h7
    } cssc_src_t;

    // Special function register write/read request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cssc_sfr_req_t;

    typedef enum {
        cssc_idle,
        cssc_convert
    } cssc_state_t;

endpackage

/* File: rtl/cssc_scan_control.sv */
// Conversion sequencing for the capacitive sense unit: trigger, accumulation, auto-scan.
// Assumes an SFR bus with one-cycle strobes, synchronous to clk, and an analog front end
// that reports a greater-than comparator event per conversion.
//
// What this block does
// - A three-bit start-source field picks the conversion trigger.
// - Software trigger: writing one to the busy bit starts a conversion.
// - Continuous modes wait for the busy bit, then convert back to back.
// - Complete interrupt request only when the complete interrupt enable is set.
// - With accumulation, completion is signalled only after the last conversion.
// - Start-source value 111b means continuous conversion with auto-scan.
// - With auto-scan on, writing scan start also loads the mux select.
// - With auto-scan on, writing one to busy starts the scan.
// - After the accumulation count, auto-scan steps mux select upward and converts.
// - At the end channel, mux select reloads the start channel and continues.
// - Every selected channel gets one attempt, analog-configured or not.
// - Auto-scan keeps running through suspend.
// - A greater-than event during suspend auto-scan wakes the device.
// - Scan start: bits 7:5 read zero, 4:0 hold the start channel, reset zero.
// - Scan end: low five bits hold the end channel, upper read zero.
`timescale 1ns/1ps
`include "cssc_params.svh"

module cssc_scan_control (
    input wire logic clk,
    input wire logic srst,
    input wire cssc_pkg::cssc_sfr_req_t sfr_req,
    input wire logic timer0_ovf,
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    input wire logic complete_irq_enable,
    input wire logic suspend,
    input wire logic greater_than_event,
    output logic [7:0] sfr_rdata,
    output logic [4:0] channel_mux_select,
    output logic conv_active,
    output logic conv_done,
    output logic complete_irq,
    output logic wake
);

    localparam int unsigned CONV_CYCLES = `CSSC_CONV_CYCLES;
    // Register state; acc_count needs four bits so that a set of sixteen can be counted.
    logic [7:0] cap_sense_config;
    logic [4:0] scan_start_channel, scan_end_channel;
    logic conversion_busy_bit, irq_flag;
    logic [15:0] conv_count;
    logic [3:0] acc_count;
    cssc_pkg::cssc_state_t state;
    logic [7:0] next_config;
    logic [4:0] next_start, next_end, next_mux;
    logic next_busy, next_irq_flag;
    logic [15:0] next_conv_count;
    logic [3:0] next_acc_count;
    cssc_pkg::cssc_state_t next_state;
    logic [7:0] next_rdata;
    logic next_done, next_complete_irq, next_wake;
    // Number of conversions per accumulation set: codes 0, 1, 2, 3 map to 1/4/8/16.
    function automatic logic [4:0] acc_total(input logic [1:0] code);
        case (code)
            2'h0: acc_total = 5'h01;
            2'h1: acc_total = 5'h04;
            2'h2: acc_total = 5'h08;
            default: acc_total = 5'h10;
        endcase
    endfunction
    // Address match helper for write strobes.
    function automatic logic wr_hit(input cssc_pkg::cssc_sfr_req_t r, input logic [7:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction
    cssc_pkg::cssc_src_t src;
    logic continuous, autoscan, trigger, busy_write, last_of_set;
    logic [4:0] acc_target;
    // Trigger selection and mode decode.
    always_comb begin
        src = cssc_pkg::cssc_src_t'(cap_sense_config[`CSSC_CFG_SRC_HI:`CSSC_CFG_SRC_LO]);
        autoscan = (src == cssc_pkg::cssc_src_autoscan);
        continuous = autoscan || (src == cssc_pkg::cssc_src_continuous);
        busy_write = wr_hit(sfr_req, `CSSC_ADDR_CONTROL) && sfr_req.wdata[`CSSC_CTL_BUSY];
        acc_target = acc_total(cap_sense_config[`CSSC_CFG_ACC_HI:`CSSC_CFG_ACC_LO]);
        case (src)
            cssc_pkg::cssc_src_software: trigger = busy_write;
            cssc_pkg::cssc_src_timer0: trigger = timer0_ovf;
            cssc_pkg::cssc_src_timer2: trigger = timer2_ovf;
            cssc_pkg::cssc_src_timer1: trigger = timer1_ovf;
            cssc_pkg::cssc_src_continuous: trigger = conversion_busy_bit || busy_write;
            cssc_pkg::cssc_src_autoscan: trigger = conversion_busy_bit || busy_write;
            default: trigger = 1'b0;
        endcase
        last_of_set = ({1'b0, acc_count} + 5'h01) >= acc_target;
    end
    // Register, sequencer and scan state next values.
    always_comb begin
        next_config = cap_sense_config;
        next_start = scan_start_channel;
        next_end = scan_end_channel;
        next_mux = channel_mux_select;
        next_busy = conversion_busy_bit;
        next_irq_flag = irq_flag;
        next_conv_count = conv_count;
        next_acc_count = acc_count;
        next_state = state;
        next_done = 1'b0;
        next_complete_irq = 1'b0;
        next_wake = 1'b0;
        if (wr_hit(sfr_req, `CSSC_ADDR_CONFIG)) begin
            next_config = sfr_req.wdata;
        end
        if (wr_hit(sfr_req, `CSSC_ADDR_SCAN_START)) begin
            next_start = sfr_req.wdata[4:0];
            if (autoscan) begin
                next_mux = sfr_req.wdata[4:0];
            end
        end
        if (wr_hit(sfr_req, `CSSC_ADDR_SCAN_END)) begin
            next_end = sfr_req.wdata[4:0];
        end
        if (wr_hit(sfr_req, `CSSC_ADDR_MUX_SELECT)) begin
            next_mux = sfr_req.wdata[4:0];
        end
        if (wr_hit(sfr_req, `CSSC_ADDR_CONTROL)) begin
            // Writing zero to the flag clears it; a completion this cycle wins below.
            if (!sfr_req.wdata[`CSSC_CTL_IRQ_FLAG]) begin
                next_irq_flag = 1'b0;
            end
            // Writing zero to busy stops continuous conversion after the current accumulation set.
            if (sfr_req.wdata[`CSSC_CTL_BUSY]) begin
                next_busy = 1'b1;
            end else if (continuous) begin
                next_busy = 1'b0;
            end
        end
        case (state)
            cssc_pkg::cssc_idle: begin
                if (trigger) begin
                    next_busy = 1'b1;
                    next_conv_count = 16'h0000;
                    next_state = cssc_pkg::cssc_convert;
                end
            end
            cssc_pkg::cssc_convert: begin
                next_conv_count = conv_count + 16'h0001;
                if (conv_count == 16'(CONV_CYCLES - 1)) begin
                    next_conv_count = 16'h0000;
                    if (autoscan && suspend && greater_than_event) begin
                        next_wake = 1'b1;
                    end
                    if (last_of_set) begin
                        next_acc_count = 4'h0;
                        next_done = 1'b1;
                        next_irq_flag = 1'b1;
                        next_complete_irq = complete_irq_enable;
                        if (autoscan) begin
                            if (channel_mux_select == scan_end_channel) begin
                                next_mux = scan_start_channel;
                            end else begin
                                next_mux = channel_mux_select + 5'h01;
                            end
                        end
                        if (!continuous) begin
                            next_busy = 1'b0;
                            next_state = cssc_pkg::cssc_idle;
                        end else if (!next_busy) begin
                            next_state = cssc_pkg::cssc_idle;
                        end
                    end else begin
                        next_acc_count = acc_count + 4'h1;
                    end
                end
            end
            default: next_state = cssc_pkg::cssc_idle;
        endcase
    end
    // Read data for the SFR bus, upper bits of channel registers read as zero.
    always_comb begin
        case (sfr_req.addr)
            `CSSC_ADDR_CONFIG: next_rdata = cap_sense_config;
            `CSSC_ADDR_CONTROL: next_rdata = {6'h00, next_busy, next_irq_flag};
            `CSSC_ADDR_SCAN_START: next_rdata = {3'h0, next_start};
            `CSSC_ADDR_SCAN_END: next_rdata = {3'h0, next_end};
            `CSSC_ADDR_MUX_SELECT: next_rdata = {3'h0, next_mux};
            default: next_rdata = 8'h00;
        endcase
    end
    // State registers; suspend gates only the wake pulse, so a scan keeps running.
    // Scan runs in suspend.
    always_ff @(posedge clk) begin
        if (srst) begin
            cap_sense_config <= `CSSC_RESET_BYTE;
            scan_start_channel <= 5'h00;
            scan_end_channel <= 5'h00;
            channel_mux_select <= 5'h00;
            conversion_busy_bit <= 1'b0;
            irq_flag <= 1'b0;
            conv_count <= 16'h0000;
            acc_count <= 4'h0;
            state <= cssc_pkg::cssc_idle;
            sfr_rdata <= 8'h00;
            conv_active <= 1'b0;
            conv_done <= 1'b0;
            complete_irq <= 1'b0;
            wake <= 1'b0;
        end else begin
            cap_sense_config <= next_config;
            scan_start_channel <= next_start;
            scan_end_channel <= next_end;
            channel_mux_select <= next_mux;
            conversion_busy_bit <= next_busy;
            irq_flag <= next_irq_flag;
            conv_count <= next_conv_count;
            acc_count <= next_acc_count;
            state <= next_state;
            sfr_rdata <= sfr_req.rd ? next_rdata : 8'h00;
            conv_active <= (next_state == cssc_pkg::cssc_convert);
            conv_done <= next_done;
            complete_irq <= next_complete_irq;
            wake <= next_wake;
        end
    end
    // Checks on the sequencing.
    property p_irq_gate;
        @(posedge clk) disable iff (srst) complete_irq |-> conv_done && $past(complete_irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
    property p_start_copy;
        @(posedge clk) disable iff (srst)
            wr_hit(sfr_req, `CSSC_ADDR_SCAN_START) && autoscan && state == cssc_pkg::cssc_idle
            |=> channel_mux_select == $past(sfr_req.wdata[4:0]);
    endproperty
    a_start_copy: assert property (p_start_copy) else $error("mux not loaded");
    property p_wrap;
        @(posedge clk) disable iff (srst)
            conv_done && $past(autoscan) && $past(channel_mux_select) == $past(scan_end_channel)
            |-> channel_mux_select == $past(scan_start_channel);
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");
    property p_step;
        @(posedge clk) disable iff (srst)
            conv_done && $past(autoscan) && $past(channel_mux_select) != $past(scan_end_channel)
            && !$past(wr_hit(sfr_req, `CSSC_ADDR_SCAN_START))
            && !$past(wr_hit(sfr_req, `CSSC_ADDR_MUX_SELECT))
            |-> channel_mux_select == $past(channel_mux_select) + 5'h01;
    endproperty
    a_step: assert property (p_step) else $error("no step");
    property p_sw_start;
        @(posedge clk) disable iff (srst)
            state == cssc_pkg::cssc_idle && src == cssc_pkg::cssc_src_software && busy_write
            |=> conv_active && conversion_busy_bit;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("sw start missed");
    property p_cont_wait;
        @(posedge clk) disable iff (srst)
            state == cssc_pkg::cssc_idle && continuous && !conversion_busy_bit && !busy_write
            |=> !conv_active;
    endproperty
    a_cont_wait: assert property (p_cont_wait) else $error("early continuous");
    property p_acc_done;
        @(posedge clk) disable iff (srst) conv_done |-> $past(last_of_set);
    endproperty
    a_acc_done: assert property (p_acc_done) else $error("early done");
    property p_busy_clear;
        @(posedge clk) disable iff (srst)
            conv_done && !$past(continuous) && !$past(busy_write) |-> !conversion_busy_bit;
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy stuck");
    property p_upper_zero;
        @(posedge clk) disable iff (srst)
            $past(sfr_req.rd) && ($past(sfr_req.addr) == `CSSC_ADDR_SCAN_START
            || $past(sfr_req.addr) == `CSSC_ADDR_SCAN_END) |-> sfr_rdata[7:5] == 3'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
    c_done: cover property (@(posedge clk) disable iff (srst) conv_done);
    c_wrap: cover property (@(posedge clk) disable iff (srst) conv_done && autoscan
        && $past(channel_mux_select) == $past(scan_end_channel));
    c_wake: cover property (@(posedge clk) disable iff (srst) wake);
endmodule

/* File: testbench/cssc_electrode_model.sv */
// Behavioural model of the sensing electrodes seen by the scan controller.
// Assumes the comparator result is a level that the controller samples at conversion end.
`timescale 1ns/1ps

module cssc_electrode_model (
    input wire logic [4:0] channel_mux_select,
    input wire logic conv_active,
    input wire logic [4:0] touched_channel,
    output logic greater_than_event
);
    // Pads scanned by the bench count as analog-configured, so results are valid.
    // The comparator answers on whatever channel is selected, analog-configured or not.
    // Outside a conversion it reports no event, so a stale result cannot wake the device.
    always_comb begin
        greater_than_event = conv_active && (channel_mux_select == touched_channel);
    end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the capacitive sense scan controller.
// Assumes the SFR bus with one-cycle strobes and the electrode model in this folder.
`timescale 1ns/1ps
`include "cssc_params.svh"

module tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    cssc_pkg::cssc_sfr_req_t sfr_req = '0;
    logic [2:0] tick = 3'h0;
    logic irq_en = 1'b0;
    logic suspend = 1'b0;
    logic [4:0] touch_ch = 5'h1f;
    logic gt_event;
    logic [7:0] sfr_rdata;
    logic [4:0] mux;
    logic conv_active, conv_done, complete_irq, wake;
    logic [7:0] d;
    logic irq_seen, wake_seen;
    int cyc;
    int num_errors = 0;
    int n_tests = 0;

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    // Timer overflow code 1 uses tick[0], code 2 tick[1], code 3 tick[2].
    cssc_scan_control u_dut (
        .clk(clk), .srst(srst), .sfr_req(sfr_req),
        .timer0_ovf(tick[0]), .timer1_ovf(tick[2]), .timer2_ovf(tick[1]),
        .complete_irq_enable(irq_en), .suspend(suspend), .greater_than_event(gt_event),
        .sfr_rdata(sfr_rdata), .channel_mux_select(mux), .conv_active(conv_active),
        .conv_done(conv_done), .complete_irq(complete_irq), .wake(wake)
    );

    cssc_electrode_model u_pads (
        .channel_mux_select(mux), .conv_active(conv_active),
        .touched_channel(touch_ch), .greater_than_event(gt_event)
    );

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask

    // One-cycle write strobe; a gap cycle follows so strobes never merge.
    task sfr_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk);
        sfr_req <= '0;
        #1;
    endtask

    task sfr_rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        sfr_req <= '0;
        #1;
        v = sfr_rdata;
    endtask

    task pulse(input logic [2:0] v);
        @(posedge clk);
        tick <= v;
        @(posedge clk);
        tick <= 3'h0;
        #1;
    endtask

    // Bounded wait for the end of an accumulation set, capturing the side pulses.
    task wait_done(input int limit);
        cyc = 0;
        do begin
            @(posedge clk);
            #1;
            cyc++;
        end while (conv_done !== 1'b1 && cyc < limit);
        irq_seen = complete_irq;
        wake_seen = wake;
        check("done seen", conv_done, 1'b1);
    endtask

    task report_and_stop;
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs about 46000 cycles, so 80000 leaves ample margin.
    initial begin
        #800000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        // Register reset values, reserved bits and an unmapped address.
        sfr_rd(`CSSC_ADDR_SCAN_START, d);
        check("start reset", d, 8'h00);
        sfr_rd(`CSSC_ADDR_SCAN_END, d);
        check("end reset", d, 8'h00);
        sfr_rd(`CSSC_ADDR_CONTROL, d);
        check("control reset", d, 8'h00);
        sfr_wr(`CSSC_ADDR_SCAN_START, 8'hff);
        sfr_rd(`CSSC_ADDR_SCAN_START, d);
        check("start bits", d, 8'h1f);
        check("mux untouched", mux, 5'h00);
        sfr_wr(`CSSC_ADDR_SCAN_END, 8'he5);
        sfr_rd(`CSSC_ADDR_SCAN_END, d);
        check("end bits", d, 8'h05);
        sfr_rd(8'h55, d);
        check("unmapped read", d, 8'h00);
        $display("test registers done");

        // Software trigger with the complete interrupt enabled.
        @(posedge clk);
        irq_en <= 1'b1;
        sfr_wr(`CSSC_ADDR_CONFIG, 8'h00);
        sfr_wr(`CSSC_ADDR_CONTROL, 8'h02);
        check("soft start", conv_active, 1'b1);
        wait_done(4000);
        check("single time", cyc >= 3790 && cyc <= 3802, 1'b1);
        check("irq enabled", irq_seen, 1'b1);
        sfr_rd(`CSSC_ADDR_CONTROL, d);
        check("busy cleared", d[1], 1'b0);
        $display("test software trigger done");

        // Each timer code starts only on its own overflow; interrupt masked.
        @(posedge clk);
        irq_en <= 1'b0;
        for (int c = 1; c <= 3; c++) begin
            sfr_wr(`CSSC_ADDR_CONFIG, {1'b0, 3'(c), 4'h0});
            pulse(~(3'h1 << (c - 1)));
            check("other timer idle", conv_active, 1'b0);
            pulse(3'h1 << (c - 1));
            check("timer start", conv_active, 1'b1);
            wait_done(4000);
            check("irq masked", irq_seen, 1'b0);
        end
        $display("test timer triggers done");

        // Four conversions per set give one completion only.
        @(posedge clk);
        irq_en <= 1'b1;
        sfr_wr(`CSSC_ADDR_CONFIG, 8'h01);
        sfr_wr(`CSSC_ADDR_CONTROL, 8'h02);
        wait_done(16000);
        check("accumulated time", cyc >= 15190 && cyc <= 15220, 1'b1);
        check("set irq", irq_seen, 1'b1);
        $display("test accumulation done");

        // Continuous single channel waits for busy, repeats, and stops once busy is cleared.
        sfr_wr(`CSSC_ADDR_CONFIG, 8'h40);
        repeat (2) @(posedge clk);
        #1;
        check("continuous waits", conv_active, 1'b0);
        sfr_wr(`CSSC_ADDR_CONTROL, 8'h02);
        wait_done(4000);
        repeat (2) @(posedge clk);
        #1;
        check("continuous again", conv_active, 1'b1);
        check("no step", mux, 5'h00);
        sfr_rd(`CSSC_ADDR_CONTROL, d);
        check("continuous busy", d[1], 1'b1);
        sfr_wr(`CSSC_ADDR_CONTROL, 8'h00);
        wait_done(4000);
        check("continuous stops", conv_active, 1'b0);
        // A reserved start-source code never starts a conversion.
        sfr_wr(`CSSC_ADDR_CONFIG, 8'h50);
        pulse(3'h7);
        check("reserved idle", conv_active, 1'b0);
        $display("test continuous and reserved done");

        // Auto-scan over channels 2 and 3 while suspended, touch on channel 3.
        @(posedge clk);
        suspend <= 1'b1;
        touch_ch <= 5'h03;
        sfr_wr(`CSSC_ADDR_CONFIG, 8'h70);
        repeat (5) @(posedge clk);
        #1;
        check("waits for busy", conv_active, 1'b0);
        sfr_wr(`CSSC_ADDR_SCAN_END, 8'h03);
        sfr_wr(`CSSC_ADDR_SCAN_START, 8'h02);
        check("start copied", mux, 5'h02);
        sfr_wr(`CSSC_ADDR_CONTROL, 8'h02);
        check("scan start", conv_active, 1'b1);
        wait_done(4000);
        check("no wake ch2", wake_seen, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        check("step up", mux, 5'h03);
        check("back to back", conv_active, 1'b1);
        wait_done(4000);
        check("wake ch3", wake_seen, 1'b1);
        check("scan irq", irq_seen, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        check("wrap to start", mux, 5'h02);
        check("runs in suspend", conv_active, 1'b1);
        sfr_rd(`CSSC_ADDR_CONTROL, d);
        check("busy held", d[1], 1'b1);
        $display("test auto-scan done");
        report_and_stop();
    end
endmodule
